// [core/isd_consts.svh]
`ifndef ISD_CONSTS_SVH
`define ISD_CONSTS_SVH
// i/o ports seen on the expansion bus
`define ISD_RTC_ADDR_PORT 16'h0070
`define ISD_RTC_DATA_PORT 16'h0071
`define ISD_KBD_PORT_A 16'h0060
`define ISD_KBD_PORT_B 16'h0064
`define ISD_GP_LATCH_PORT 16'h00e0
// rom window: top 128k below 1m and its mirror below 16m
`define ISD_ROM_LOW_TOP 7'h07
`define ISD_ROM_HIGH_TOP 7'h7f
// idle code on the encoded acknowledge: cascade channel, never acked
`define ISD_DACK_IDLE 3'h4
// timing
`define ISD_CLK_NS 10
`define ISD_HOLD_CYC 2
`define ISD_REF_NS 280
`define ISD_CMD_NS 500
`define ISD_ZWS_NS 100
`define ISD_REF_CYC ((`ISD_REF_NS + `ISD_CLK_NS - 1) / `ISD_CLK_NS)
`define ISD_CMD_CYC ((`ISD_CMD_NS + `ISD_CLK_NS - 1) / `ISD_CLK_NS)
`define ISD_ZWS_CYC ((`ISD_ZWS_NS + `ISD_CLK_NS - 1) / `ISD_CLK_NS)
`endif

// [core/isd_pkg.sv]
package isd_pkg;
  typedef struct packed {
    logic valid;
    logic is_io;
    logic is_mem;
    logic rd;
    logic wr;
    logic [23:0] addr;
  } isd_cycle_t;

  typedef struct packed {
    logic owner;
    logic ack_valid;
    logic [2:0] ack_ch;
    logic last;
  } isd_dma_t;

  typedef enum logic [1:0] {
    RF_IDLE,
    RF_HOLD,
    RF_ISA
  } isd_rf_state_t;
endpackage

// [core/isd_sideband.sv]
// Behaviour
// - refresh holds host bus two clocks
// - address enable follows dma bus ownership
// - channel check raises nmi when enabled
// - latch select pulses on latch port write
// - rtc rw strobe on write to 71h
// - rtc data strobe on read of 71h
// - rtc address strobe on write 70h
// - shared select on rom or rtc decode
// - irq lines demultiplexed by bus clock phases
// - irq eight inverted toward interrupt controller
// - keyboard select on keyboard i/o decode
// - zero wait input shortens bus cycle
// - dma acknowledge leaves three-bit encoded
// - dma requests demultiplexed by clock phases
// - terminal count on final dma transfer
// - transceiver enabled only in isa use
// - memory read active during refresh
`include "isd_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module isd_sideband
  import isd_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // host side cycle
  input wire isd_cycle_t cyc,
  output logic cyc_done,
  // refresh
  input wire logic refresh_req,
  output logic host_bus_hold,
  output logic refresh_addr_drive,
  output logic refresh_busy,
  // dma controller
  input wire isd_dma_t dma,
  output logic [7:0] dreq_to_dmac,
  // interrupt controller and system control
  output logic [15:0] irq_to_pic,
  input wire logic chan_check_enable,
  output logic chan_check_status,
  output logic nmi,
  // pin mode
  input wire logic isa_strap,
  input wire logic ide_active,
  // pins in
  input wire logic chan_check_n,
  input wire logic zero_wait_n,
  input wire logic [3:0] muxed_irq_lines,
  input wire logic [1:0] muxed_dma_request,
  input wire logic expansion_bus_clock,
  input wire logic expansion_bus_clock_double,
  // pins out
  output logic isa_aen,
  output logic terminal_count,
  output logic memr_n,
  output logic refresh_n,
  output logic [2:0] encoded_dma_ack,
  output logic gp_latch_select_n,
  output logic clock_chip_rw_strobe_n,
  output logic clock_chip_data_strobe_n,
  output logic clock_chip_addr_strobe,
  output logic rom_or_clock_chip_select_n,
  output logic keyboard_ctrl_select_n,
  output logic bus_transceiver_oe_n
);
  localparam logic [5:0] HOLD_CYC = 6'(`ISD_HOLD_CYC);
  localparam logic [5:0] REF_CYC = 6'(`ISD_REF_CYC);
  localparam logic [5:0] CMD_CYC = 6'(`ISD_CMD_CYC);
  localparam logic [5:0] ZWS_CYC = 6'(`ISD_ZWS_CYC);

  logic [1:0] rst_sync;
  logic rst_ok_n;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_ok_n = rst_sync[1];

  // pin synchronisers: stage one feeds stage two only
  localparam int NPIN = 10;
  logic [NPIN-1:0] pin_raw, pin_s1, pin_s2;
  assign pin_raw = {expansion_bus_clock, expansion_bus_clock_double,
                    muxed_dma_request, muxed_irq_lines,
                    chan_check_n, zero_wait_n};
  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      pin_s1 <= 10'h003;
      pin_s2 <= 10'h003;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end

  wire zws_act = !pin_s2[0];
  wire chk_act = !pin_s2[1];
  wire [3:0] irq_s = pin_s2[5:2];
  wire [1:0] dreq_s = pin_s2[7:6];
  wire [1:0] phase = pin_s2[9:8];

  // demultiplexing: a slot is loaded only once its phase has settled
  logic [1:0] phase_d;
  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      phase_d <= 2'h0;
    end else begin
      phase_d <= phase;
    end
  end
  wire phase_stable = (phase == phase_d);

  logic [15:0] irq_slot;
  logic [7:0] dreq_slot;
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_irq
      wire take = phase_stable && (phase == 2'(gi / 4));
      always_ff @(posedge mclk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
          irq_slot[gi] <= 1'b0;
        end else if (take) begin
          irq_slot[gi] <= irq_s[gi % 4];
        end
      end
    end
    for (gi = 0; gi < 8; gi++) begin : g_dreq
      wire take = phase_stable && (phase == 2'(gi / 2));
      always_ff @(posedge mclk or negedge rst_ok_n) begin
        if (!rst_ok_n) begin
          dreq_slot[gi] <= 1'b0;
        end else if (take) begin
          dreq_slot[gi] <= dreq_s[gi % 2];
        end
      end
    end
  endgenerate
  // the rtc drives its interrupt active low
  assign irq_to_pic = irq_slot ^ 16'h0100;
  assign dreq_to_dmac = dreq_slot;

  // refresh sequencer
  isd_rf_state_t rf_state, next_rf_state;
  logic [5:0] rf_cnt, next_rf_cnt;
  always_comb begin
    next_rf_state = rf_state;
    next_rf_cnt = rf_cnt + 6'h01;
    case (rf_state)
      RF_IDLE: begin
        next_rf_cnt = 6'h00;
        if (refresh_req) begin
          next_rf_state = RF_HOLD;
        end
      end
      RF_HOLD: begin
        if (rf_cnt == HOLD_CYC - 6'h01) begin
          next_rf_state = RF_ISA;
          next_rf_cnt = 6'h00;
        end
      end
      RF_ISA: begin
        if (rf_cnt == REF_CYC - 6'h01) begin
          next_rf_state = RF_IDLE;
          next_rf_cnt = 6'h00;
        end
      end
      default: begin
        next_rf_state = RF_IDLE;
        next_rf_cnt = 6'h00;
      end
    endcase
  end
  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      rf_state <= RF_IDLE;
      rf_cnt <= 6'h00;
    end else begin
      rf_state <= next_rf_state;
      rf_cnt <= next_rf_cnt;
    end
  end
  // host bus is released as soon as the address sits in the buffers
  assign host_bus_hold = (rf_state == RF_HOLD);
  assign refresh_addr_drive = (rf_state == RF_HOLD);
  assign refresh_busy = (rf_state != RF_IDLE);

  // command timer for host cycles; refresh owns the bus meanwhile
  logic cmd_run;
  logic [5:0] cmd_cnt;
  // held after done so a cycle still marked valid is not run twice
  logic done_hold;
  wire cmd_start = cyc.valid && !cmd_run && !cyc_done && !done_hold && !refresh_busy;
  wire cmd_full = (cmd_cnt == CMD_CYC - 6'h01);
  wire cmd_short = zws_act && (cmd_cnt >= ZWS_CYC - 6'h01);
  wire cmd_end = cmd_run && (cmd_full || cmd_short);
  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      cmd_run <= 1'b0;
      cmd_cnt <= 6'h00;
      done_hold <= 1'b0;
    end else begin
      cmd_run <= cmd_start || (cmd_run && !cmd_end);
      cmd_cnt <= cmd_run ? cmd_cnt + 6'h01 : 6'h00;
      done_hold <= cyc.valid && (done_hold || cmd_end);
    end
  end
  assign cyc_done = cmd_end;

  // address decodes
  wire io_cmd = cmd_run && cyc.is_io;
  wire mem_cmd = cmd_run && cyc.is_mem;
  wire [15:0] io_port = cyc.addr[15:0];
  wire [6:0] top7 = cyc.addr[23:17];
  wire hit_rtc_a = (io_port == `ISD_RTC_ADDR_PORT);
  wire hit_rtc_d = (io_port == `ISD_RTC_DATA_PORT);
  wire hit_kbd = (io_port == `ISD_KBD_PORT_A) || (io_port == `ISD_KBD_PORT_B);
  wire hit_gp = (io_port == `ISD_GP_LATCH_PORT);
  wire hit_rom = (top7 == `ISD_ROM_LOW_TOP) || (top7 == `ISD_ROM_HIGH_TOP);
  wire dec_rtc_rw = io_cmd && cyc.wr && hit_rtc_d;
  wire dec_rtc_ds = io_cmd && cyc.rd && hit_rtc_d;
  wire dec_rtc_as = io_cmd && cyc.wr && hit_rtc_a;
  wire dec_romrtc = (mem_cmd && hit_rom) || (io_cmd && (hit_rtc_a || hit_rtc_d));
  wire dec_kbd = io_cmd && hit_kbd;
  wire dec_gp = io_cmd && cyc.wr && hit_gp;
  wire dec_memr = (mem_cmd && cyc.rd) || (rf_state == RF_ISA);
  wire dec_ack = dma.owner && dma.ack_valid;
  wire [2:0] next_dack = dec_ack ? dma.ack_ch : `ISD_DACK_IDLE;
  wire next_nmi = chk_act && chan_check_enable;

  // the transceiver mode strap is taken once, after reset release
  logic strap_taken, isa_mode;
  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      strap_taken <= 1'b0;
      isa_mode <= 1'b0;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      isa_mode <= isa_strap;
    end
  end

  // output flops
  always_ff @(posedge mclk or negedge rst_ok_n) begin
    if (!rst_ok_n) begin
      clock_chip_rw_strobe_n <= 1'b1;
      clock_chip_data_strobe_n <= 1'b1;
      clock_chip_addr_strobe <= 1'b0;
      rom_or_clock_chip_select_n <= 1'b1;
      keyboard_ctrl_select_n <= 1'b1;
      gp_latch_select_n <= 1'b1;
      memr_n <= 1'b1;
      refresh_n <= 1'b1;
      isa_aen <= 1'b0;
      terminal_count <= 1'b0;
      encoded_dma_ack <= `ISD_DACK_IDLE;
      nmi <= 1'b0;
      chan_check_status <= 1'b0;
      bus_transceiver_oe_n <= 1'b1;
    end else begin
      clock_chip_rw_strobe_n <= !dec_rtc_rw;
      clock_chip_data_strobe_n <= !dec_rtc_ds;
      clock_chip_addr_strobe <= dec_rtc_as;
      rom_or_clock_chip_select_n <= !dec_romrtc;
      keyboard_ctrl_select_n <= !dec_kbd;
      gp_latch_select_n <= !dec_gp;
      memr_n <= !dec_memr;
      refresh_n <= !(rf_state == RF_ISA);
      isa_aen <= dma.owner;
      terminal_count <= dma.owner && dma.last;
      encoded_dma_ack <= next_dack;
      nmi <= next_nmi;
      chan_check_status <= chk_act;
      bus_transceiver_oe_n <= !(strap_taken && isa_mode && !ide_active);
    end
  end

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_ok_n);

  chk_hold_two_cycles: assert property (
    $rose(host_bus_hold) |-> host_bus_hold ##1 (host_bus_hold ##1 !host_bus_hold))
    else $error("host bus hold not exactly two cycles");
  chk_memr_in_refresh: assert property (
    $fell(host_bus_hold) |=> !memr_n [*3])
    else $error("memory read idle during refresh");
  chk_aen_dma_owner: assert property (
    isa_aen == $past(dma.owner))
    else $error("address enable differs from dma ownership");
  chk_nmi_enable_gate: assert property (
    nmi |-> $past(chan_check_enable) && $past(chk_act))
    else $error("nmi without enabled channel check");
  chk_nmi_masked: assert property (
    !chan_check_enable |=> !nmi)
    else $error("nmi stays with enable cleared");
  chk_rtc_rw_port: assert property (
    !clock_chip_rw_strobe_n |-> $past(cyc.wr && cyc.is_io && io_port == 16'h0071))
    else $error("rtc rw strobe off port");
  chk_rtc_ds_port: assert property (
    (cmd_run && cyc.is_io && cyc.rd && hit_rtc_d) |=> !clock_chip_data_strobe_n)
    else $error("rtc data strobe missing");
  chk_rtc_as_port: assert property (
    clock_chip_addr_strobe |-> $past(cyc.wr && io_port == 16'h0070))
    else $error("rtc address strobe off port");
  chk_zws_shortens: assert property (
    (cmd_run && zws_act) [*8] |-> ##[1:4] !cmd_run)
    else $error("zero wait did not shorten cycle");
  chk_irq8_inverted: assert property (
    (phase_stable && phase == 2'h2) |=> irq_to_pic[8] != $past(irq_s[0]))
    else $error("irq eight not inverted");
  chk_dack_idle: assert property (
    !$past(dma.owner && dma.ack_valid) |-> encoded_dma_ack == 3'h4)
    else $error("encoded ack not idle");
  chk_oe_ide: assert property (
    $past(ide_active) |-> bus_transceiver_oe_n)
    else $error("transceiver on during ide use");
  chk_kbd_select: assert property (
    (cmd_run && cyc.is_io && (io_port == `ISD_KBD_PORT_A || io_port == `ISD_KBD_PORT_B)) |=> !keyboard_ctrl_select_n)
    else $error("keyboard select missing");
  chk_rom_select: assert property (
    (cmd_run && cyc.is_mem && hit_rom) |=> !rom_or_clock_chip_select_n)
    else $error("rom select missing");
  chk_tc_last: assert property (
    terminal_count |-> $past(dma.owner && dma.last))
    else $error("terminal count without final transfer");
  chk_gp_latch_write: assert property (
    !gp_latch_select_n |-> $past(cyc.wr && cyc.is_io))
    else $error("latch select outside i/o write");
  chk_dack_channel: assert property (
    $past(dma.owner && dma.ack_valid) |-> encoded_dma_ack == $past(dma.ack_ch))
    else $error("encoded ack differs from channel");

  cov_refresh: cover property (rf_state == RF_ISA ##1 rf_state == RF_IDLE);
  cov_zws_cycle: cover property (cmd_end && cmd_short && !cmd_full);
  cov_nmi: cover property ($rose(nmi));
  cov_dack: cover property (encoded_dma_ack != 3'h4 && terminal_count);
  cov_kbd: cover property (!keyboard_ctrl_select_n);
endmodule
`default_nettype wire

// [testbench/isd_card_model.sv]
`timescale 1ns/1ps
`default_nettype none
module isd_card_model (
  // clock
  input wire logic mclk,
  // request levels of the cards
  input wire logic [15:0] irq_req,
  input wire logic [7:0] dreq_req,
  // pins
  output logic expansion_bus_clock,
  output logic expansion_bus_clock_double,
  output logic [3:0] muxed_irq_lines,
  output logic [1:0] muxed_dma_request,
  input wire logic [2:0] encoded_dma_ack,
  output logic [7:0] dack_seen
);
  logic [4:0] ph_cnt = 5'h00;
  logic [1:0] ph;
  // bus clocks run free; eight mclk a phase keeps each phase clear of the sync flops
  always @(posedge mclk) ph_cnt <= ph_cnt + 5'h01;
  assign ph = ph_cnt[4:3];
  assign expansion_bus_clock = ph[1];
  assign expansion_bus_clock_double = ph[0];
  assign muxed_irq_lines = irq_req[{ph, 2'h0} +: 4];
  assign muxed_dma_request = dreq_req[{ph, 1'h0} +: 2];
  // code 4 is the idle code, so channel 4 is never decoded
  assign dack_seen = (encoded_dma_ack == 3'h4) ? 8'h00 : 8'h01 << encoded_dma_ack;
endmodule
`default_nettype wire

// [testbench/isd_sideband_test.sv]
`include "isd_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module isd_sideband_test;
  import isd_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  isd_cycle_t cyc = '0;
  isd_dma_t dma = '0;
  logic refresh_req = 1'b0;
  logic chan_check_enable = 1'b0;
  logic isa_strap = 1'b1;
  logic ide_active = 1'b0;
  logic chan_check_n = 1'b1;
  logic zero_wait_n = 1'b1;
  logic [15:0] irq_req = 16'h0000;
  logic [7:0] dreq_req = 8'h00;
  logic cyc_done, host_bus_hold, refresh_addr_drive, refresh_busy, chan_check_status, nmi;
  logic [7:0] dreq_to_dmac, dack_seen;
  logic [15:0] irq_to_pic;
  logic expansion_bus_clock, expansion_bus_clock_double;
  logic [3:0] muxed_irq_lines;
  logic [1:0] muxed_dma_request;
  logic isa_aen, terminal_count, memr_n, refresh_n, bus_transceiver_oe_n;
  logic [2:0] encoded_dma_ack;
  logic gp_latch_select_n, clock_chip_rw_strobe_n, clock_chip_data_strobe_n;
  logic clock_chip_addr_strobe, rom_or_clock_chip_select_n, keyboard_ctrl_select_n;
  logic [6:0] strobes;
  int err_total = 0;
  int checked = 0;
  assign strobes = {~memr_n, ~gp_latch_select_n, ~clock_chip_rw_strobe_n, ~clock_chip_data_strobe_n,
    clock_chip_addr_strobe, ~rom_or_clock_chip_select_n, ~keyboard_ctrl_select_n};
  always #5 mclk = ~mclk;
  isd_sideband dut (.mclk, .rst_n, .cyc, .cyc_done, .refresh_req, .host_bus_hold,
    .refresh_addr_drive, .refresh_busy, .dma, .dreq_to_dmac, .irq_to_pic, .chan_check_enable,
    .chan_check_status, .nmi, .isa_strap, .ide_active, .chan_check_n, .zero_wait_n,
    .muxed_irq_lines, .muxed_dma_request, .expansion_bus_clock, .expansion_bus_clock_double,
    .isa_aen, .terminal_count, .memr_n, .refresh_n, .encoded_dma_ack, .gp_latch_select_n,
    .clock_chip_rw_strobe_n, .clock_chip_data_strobe_n, .clock_chip_addr_strobe,
    .rom_or_clock_chip_select_n, .keyboard_ctrl_select_n, .bus_transceiver_oe_n);
  isd_card_model card (.mclk, .irq_req, .dreq_req, .expansion_bus_clock,
    .expansion_bus_clock_double, .muxed_irq_lines, .muxed_dma_request, .encoded_dma_ack,
    .dack_seen);
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic cmp_vec(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic cmp_range(input int got, input int lo, input int hi, input string what);
    checked++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[FAIL] %0t %s count %0d", $time, what, got);
    end
  endtask
  function automatic isd_cycle_t mk(input logic io, input logic rd, input logic [23:0] a);
    return '{valid: 1'b1, is_io: io, is_mem: ~io, rd: rd, wr: ~rd, addr: a};
  endfunction
  function automatic logic [6:0] exp_strobes(input isd_cycle_t c);
    logic [15:0] p;
    logic rom;
    p = c.addr[15:0];
    rom = c.addr[23:17] == `ISD_ROM_LOW_TOP || c.addr[23:17] == `ISD_ROM_HIGH_TOP;
    return {c.is_mem && c.rd,
      c.is_io && c.wr && p == `ISD_GP_LATCH_PORT, c.is_io && c.wr && p == `ISD_RTC_DATA_PORT,
      c.is_io && c.rd && p == `ISD_RTC_DATA_PORT, c.is_io && c.wr && p == `ISD_RTC_ADDR_PORT,
      (c.is_io && (p == `ISD_RTC_ADDR_PORT || p == `ISD_RTC_DATA_PORT)) || (c.is_mem && rom),
      c.is_io && (p == `ISD_KBD_PORT_A || p == `ISD_KBD_PORT_B)};
  endfunction
  task automatic bus_cycle(input isd_cycle_t c, input logic zws);
    int n;
    cyc = c;
    zero_wait_n = ~zws;
    tick(6);
    cmp_vec(16'(strobes), 16'(exp_strobes(c)), "strobes");
    n = 6;
    while (cyc_done !== 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    if (zws) cmp_range(n, 8, 16, "zws");
    else cmp_range(n, 47, 53, "cmd");
    cyc.valid = 1'b0;
    zero_wait_n = 1'b1;
    tick(2);
    cmp_vec(16'(strobes), 16'h0000, "idle");
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    report_and_stop();
  end
  initial begin
    isd_cycle_t tbl[$];
    int h;
    int d;
    int m;
    int b;
    void'($urandom(17));
    tick(5);
    cmp_vec(16'(encoded_dma_ack), 16'h0004, "ack rst");
    cmp_vec(16'(strobes), 16'h0000, "strobes rst");
    cmp_vec(16'(bus_transceiver_oe_n), 16'h0001, "oe rst");
    rst_n = 1'b1;
    tick(4);
    cmp_vec(16'(bus_transceiver_oe_n), 16'h0000, "oe isa");
    ide_active = 1'b1;
    tick(3);
    cmp_vec(16'(bus_transceiver_oe_n), 16'h0001, "oe ide");
    ide_active = 1'b0;
    tbl = {mk(1, 0, 24'h70), mk(1, 0, 24'h71), mk(1, 1, 24'h71), mk(1, 1, 24'h70),
      mk(1, 1, 24'h60), mk(1, 0, 24'h64), mk(1, 0, 24'he0), mk(1, 0, 24'h72),
      mk(0, 1'($urandom), {`ISD_ROM_LOW_TOP, 17'($urandom)}),
      mk(0, 1'($urandom), {`ISD_ROM_HIGH_TOP, 17'($urandom)}), mk(0, 1, 24'h0e0000)};
    foreach (tbl[i]) bus_cycle(tbl[i], i == 3 || i == 9);
    refresh_req = 1'b1;
    tick(1);
    refresh_req = 1'b0;
    h = 0;
    d = 0;
    m = 0;
    b = 0;
    repeat (40) begin
      if (host_bus_hold === 1'b1) h++;
      if (refresh_busy === 1'b1) b++;
      if (refresh_addr_drive === 1'b1) d++;
      if (memr_n === 1'b0 && refresh_n === 1'b0) m++;
      if (host_bus_hold === 1'b1 && memr_n === 1'b0) m += 100;
      tick(1);
    end
    cmp_range(h, 2, 2, "hold");
    cmp_range(d, 2, 2, "drive");
    cmp_range(m, 28, 28, "memr");
    cmp_range(b, 30, 30, "busy");
    for (int ch = 0; ch < 8; ch++) begin
      if (ch == 4) continue;
      dma = '{owner: 1'b1, ack_valid: 1'b1, ack_ch: 3'(ch), last: ch == 7};
      tick(2);
      cmp_vec(16'(encoded_dma_ack), 16'(ch), "ack");
      cmp_vec(16'(dack_seen), 16'(8'h01 << ch), "dack");
      cmp_vec(16'(isa_aen), 16'h0001, "aen");
      cmp_vec(16'(terminal_count), 16'(ch == 7), "tc");
    end
    dma = '0;
    tick(2);
    cmp_vec(16'(encoded_dma_ack), 16'h0004, "ack idle");
    cmp_vec(16'(isa_aen), 16'h0000, "aen off");
    chan_check_n = 1'b0;
    tick(5);
    cmp_vec(16'(nmi), 16'h0000, "nmi masked");
    cmp_vec(16'(chan_check_status), 16'h0001, "chk status");
    chan_check_enable = 1'b1;
    tick(2);
    cmp_vec(16'(nmi), 16'h0001, "nmi on");
    chan_check_enable = 1'b0;
    tick(2);
    cmp_vec(16'(nmi), 16'h0000, "nmi drop");
    chan_check_enable = 1'b1;
    chan_check_n = 1'b1;
    tick(5);
    cmp_vec(16'(nmi), 16'h0000, "nmi off");
    cmp_vec(16'(chan_check_status), 16'h0000, "chk clear");
    for (int i = 0; i < 6; i++) begin
      irq_req = (i == 0) ? 16'h0100 : (i == 1) ? 16'hfeff : 16'($urandom);
      dreq_req = (i == 0) ? 8'h81 : 8'($urandom);
      tick(80);
      cmp_vec(irq_to_pic, irq_req ^ 16'h0100, "irq");
      cmp_vec(16'(dreq_to_dmac), 16'(dreq_req), "dreq");
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
